// ==== core/via_pkg.sv ====
// Purpose: Shared constants for the vectored interrupt arbiter.
// Assumes: Sources are numbered by their default priority, zero first.
// Notes: Vector of maskable source n is the base plus two times n.
package via_pkg;
    // =====================================================================
    // Source counts and indices
    // =====================================================================
    localparam int VIA_NUM_SRC = 19;
    localparam int VIA_IDX_W = 5;
    localparam int VIA_SRC_WDT = 0;
    localparam int VIA_SRC_PIN0 = 1;
    localparam int VIA_SRC_PIN1 = 2;
    localparam int VIA_SRC_SER_TX = 3;
    localparam int VIA_SRC_SER_RX = 4;
    localparam int VIA_SRC_RX_ERR = 5;
    localparam int VIA_SRC_TM1_UP = 6;
    localparam int VIA_SRC_TM0 = 7;
    localparam int VIA_SRC_TM1 = 8;
    localparam int VIA_SRC_ADC = 9;
    localparam int VIA_SRC_KEY = 10;
    localparam int VIA_SRC_PIN2 = 11;
    localparam int VIA_SRC_PIN3 = 12;
    localparam int VIA_SRC_TM3_UP = 13;
    localparam int VIA_SRC_TWC = 14;
    localparam int VIA_SRC_TM2 = 15;
    localparam int VIA_SRC_TM3 = 16;
    localparam int VIA_SRC_ITV = 17;
    localparam int VIA_SRC_CMP = 18;

    // =====================================================================
    // Vectors, levels, opcodes and reset values
    // =====================================================================
    localparam logic [15:0] VIA_VEC_RESET = 16'h0000;
    localparam logic [15:0] VIA_VEC_BASE = 16'h0004;
    localparam logic [15:0] VIA_VEC_STEP = 16'h0002;
    localparam logic [15:0] VIA_VEC_BRK = 16'h007e;
    localparam logic [7:0] VIA_OPC_ILLEGAL = 8'hff;
    localparam logic [1:0] VIA_LVL_LOWEST = 2'h3;
    localparam logic VIA_MASK_RST = 1'h1;
    localparam logic VIA_PR_RST = 1'h1;
    localparam logic VIA_FLAG_RST = 1'h0;
endpackage : via_pkg

// ==== core/via_req_cell.sv ====
// Purpose: One request flag of the vectored interrupt arbiter.
// Assumes: Set, acknowledge clear and software clear are one-cycle pulses.
// Notes: A set in the same cycle as a clear keeps the flag set.
`timescale 1ns/1ns
`default_nettype none
module via_req_cell
    import via_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic srst,
    // Flag control.
    input wire logic set_evt,
    input wire logic clr_ack,
    input wire logic clr_sw,
    // Flag state.
    output logic flag_ff
);
    // =====================================================================
    // State
    // =====================================================================
    typedef struct packed {
        logic flag;
    } via_cell_st_t;

    via_cell_st_t st_ff;
    via_cell_st_t nxt_st;

    // =====================================================================
    // Next state
    // =====================================================================
    always_comb begin
        nxt_st = st_ff;
        // [R21] Set and clear.
        if (set_evt) begin
            nxt_st.flag = 1'h1;
        end else if (clr_ack || clr_sw) begin
            nxt_st.flag = 1'h0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_ff.flag <= VIA_FLAG_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign flag_ff = st_ff.flag;
endmodule : via_req_cell
`default_nettype wire

// ==== core/via_arbiter.sv ====
// Purpose: Vectored interrupt arbiter resolving request sources to one vector.
// Assumes: Core raises accept_window at instruction boundaries it can interrupt.
// Notes: Reset branch beats software break, which beats maskable requests.
//
// Behaviour
// [R1] Each maskable source has a two-bit level; levels decide before fixed order.
// [R2] A higher-level request can preempt a handler running at a lower level.
// [R3] Equal levels resolve by default order, lowest source number wins.
// [R4] Any pending unmasked request raises the standby release output.
// [R5] Software break vectors through 007EH regardless of enable and arbitration.
// [R6] All vectors are sixteen-bit addresses inside the first 64 K.
// [R7] Pin reset, power-on reset, watchdog overflow and trap branch to 0000H.
// [R8] Executing opcode FFH triggers the trap reset.
// [R9] Under debug emulation an illegal opcode raises no trap reset.
// [R10] Watchdog interval request is source 0, vector 0004H.
// [R11] Pin edge requests 0 and 1 are sources 1 and 2, vectors 0006H, 0008H.
// [R12] Serial transmit, clocked serial 0 and two-wire end share source 3, 000AH.
// [R13] Serial receive end, shared with clocked serial 1, is source 4, 000CH.
// [R14] Receive error is source 5, vector 000EH.
// [R15] Timer channel 1 upper, channel 0, channel 1 are sources 6 to 8.
// [R16] Conversion end is source 9 at 0016H; key return source 10 at 0018H.
// [R17] Pin edges 2 and 3 at 001AH, 001CH; two-wire controller source 14, 0020H.
// [R18] Timer 3 upper, timer 2, timer 3 are sources 13, 15, 16.
// [R19] Interval timer and comparator are sources 17 and 18, lowest order.
// [R20] After a handler the core resumes the interrupted flow.
// [R21] Flags set on request, clear on acknowledge, clear on reset.
// [R22] Mask bits reset to one; zero enables servicing.
// [R23] The three shared serial events set one flag under one mask and level.
// [R24] Acknowledge needs global enable, clear mask, level not below in-service.
// [R25] Acknowledge presents the vector and the new in-service level.
`timescale 1ns/1ns
`default_nettype none
module via_arbiter
    import via_pkg::*;
#(
    parameter int NUM_SRC = VIA_NUM_SRC
)
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic srst,
    // Maskable request events.
    input wire logic watchdog_interval_req,
    input wire logic pin_edge_req_0,
    input wire logic pin_edge_req_1,
    input wire logic serial_tx_end_req,
    input wire logic clocked_serial0_end_req,
    input wire logic simple_twowire_end_req,
    input wire logic serial_rx_end_req,
    input wire logic clocked_serial1_end_req,
    input wire logic serial_rx_error_req,
    input wire logic timer_ch1_upper_req,
    input wire logic timer_ch0_req,
    input wire logic timer_ch1_req,
    input wire logic conversion_done_req,
    input wire logic key_return_req,
    input wire logic pin_edge_req_2,
    input wire logic pin_edge_req_3,
    input wire logic timer_ch3_upper_req,
    input wire logic twowire_ctrl_end_req,
    input wire logic timer_ch2_req,
    input wire logic timer_ch3_req,
    input wire logic interval_timer_req,
    input wire logic comparator_edge_req,
    // Software configuration.
    input wire logic cfg_wr,
    input wire logic [NUM_SRC-1:0] cfg_mask_in,
    input wire logic [NUM_SRC-1:0] cfg_pr0_in,
    input wire logic [NUM_SRC-1:0] cfg_pr1_in,
    input wire logic [NUM_SRC-1:0] flag_sw_clr,
    // Core status.
    input wire logic global_irq_enable,
    input wire logic in_service_level_bit0,
    input wire logic in_service_level_bit1,
    input wire logic accept_window,
    input wire logic software_break_instr,
    input wire logic opcode_exec,
    input wire logic [7:0] opcode_in,
    input wire logic debug_emulation,
    // Reset causes.
    input wire logic ext_reset_pin,
    input wire logic selectable_power_on_reset,
    input wire logic watchdog_overflow,
    // Answer to the core.
    output logic irq_ack_ff,
    output logic [15:0] vector_ff,
    output logic [1:0] new_level_ff,
    output logic reset_branch_ff,
    output logic trap_reset_ff,
    output logic standby_release_ff,
    // Status.
    output logic [NUM_SRC-1:0] req_flags_ff,
    output logic [NUM_SRC-1:0] source_mask_flag_ff,
    output logic [NUM_SRC-1:0] priority_select_bit0_ff,
    output logic [NUM_SRC-1:0] priority_select_bit1_ff
);
    // =====================================================================
    // State
    // =====================================================================
    typedef struct packed {
        logic ack;
        logic mask_ack;
        logic [15:0] vec;
        logic [1:0] lvl;
        logic rst_br;
        logic trap;
        logic stby;
        logic [NUM_SRC-1:0] mask;
        logic [NUM_SRC-1:0] pr0;
        logic [NUM_SRC-1:0] pr1;
    } via_st_t;

    via_st_t st_ff;
    via_st_t nxt_st;
    logic [NUM_SRC-1:0] evt;
    logic [NUM_SRC-1:0] flags;
    logic [NUM_SRC-1:0] ack_clr;
    logic [1:0] isp;
    logic trap_now;
    logic rst_now;

    // =====================================================================
    // Source mapping
    // =====================================================================
    always_comb begin
        evt = '0;
        // [R10] Watchdog interval source.
        evt[VIA_SRC_WDT] = watchdog_interval_req;
        // [R11] Pin edge sources.
        evt[VIA_SRC_PIN0] = pin_edge_req_0;
        evt[VIA_SRC_PIN1] = pin_edge_req_1;
        // [R12] Shared serial end.
        // [R23] One shared flag.
        evt[VIA_SRC_SER_TX] = serial_tx_end_req | clocked_serial0_end_req
            | simple_twowire_end_req;
        // [R13] Shared receive end.
        evt[VIA_SRC_SER_RX] = serial_rx_end_req | clocked_serial1_end_req;
        // [R14] Receive error source.
        evt[VIA_SRC_RX_ERR] = serial_rx_error_req;
        // [R15] Timer sources.
        evt[VIA_SRC_TM1_UP] = timer_ch1_upper_req;
        evt[VIA_SRC_TM0] = timer_ch0_req;
        evt[VIA_SRC_TM1] = timer_ch1_req;
        // [R16] Conversion and key.
        evt[VIA_SRC_ADC] = conversion_done_req;
        evt[VIA_SRC_KEY] = key_return_req;
        // [R17] Extra pins, controller.
        evt[VIA_SRC_PIN2] = pin_edge_req_2;
        evt[VIA_SRC_PIN3] = pin_edge_req_3;
        evt[VIA_SRC_TWC] = twowire_ctrl_end_req;
        // [R18] Extra timer sources.
        evt[VIA_SRC_TM3_UP] = timer_ch3_upper_req;
        evt[VIA_SRC_TM2] = timer_ch2_req;
        evt[VIA_SRC_TM3] = timer_ch3_req;
        // [R19] Lowest order sources.
        evt[VIA_SRC_ITV] = interval_timer_req;
        evt[VIA_SRC_CMP] = comparator_edge_req;
    end

    // =====================================================================
    // Request flags
    // =====================================================================
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_flag
        via_req_cell u_cell (
            .clk_sys(clk_sys),
            .srst(srst),
            .set_evt(evt[g]),
            .clr_ack(ack_clr[g]),
            .clr_sw(flag_sw_clr[g]),
            .flag_ff(flags[g])
        );
    end

    // [R20] Level restored by core.
    assign isp = {in_service_level_bit1, in_service_level_bit0};
    // [R8] Illegal opcode detect.
    // [R9] Suppressed under debug.
    assign trap_now = opcode_exec && (opcode_in == VIA_OPC_ILLEGAL) && !debug_emulation;
    assign rst_now = ext_reset_pin || selectable_power_on_reset || watchdog_overflow
        || trap_now;

    // =====================================================================
    // Arbitration and next state
    // =====================================================================
    always_comb begin
        logic found;
        logic [1:0] best_lvl;
        logic [VIA_IDX_W-1:0] best_idx;
        logic [1:0] lvl_i;
        found = 1'h0;
        best_lvl = VIA_LVL_LOWEST;
        best_idx = '0;
        lvl_i = VIA_LVL_LOWEST;
        nxt_st = st_ff;
        ack_clr = '0;
        nxt_st.ack = 1'h0;
        nxt_st.mask_ack = 1'h0;
        nxt_st.rst_br = 1'h0;
        nxt_st.trap = 1'h0;
        // [R4] Standby release.
        nxt_st.stby = |(flags & ~st_ff.mask);
        // [R22] Software writes mask.
        if (cfg_wr) begin
            nxt_st.mask = cfg_mask_in;
            nxt_st.pr0 = cfg_pr0_in;
            nxt_st.pr1 = cfg_pr1_in;
        end
        for (int i = 0; i < NUM_SRC; i++) begin
            lvl_i = {st_ff.pr1[i], st_ff.pr0[i]};
            // [R24] Qualify each source.
            if (flags[i] && !st_ff.mask[i] && (lvl_i <= isp)) begin
                // [R1] Level first.
                // [R3] Strict compare keeps order.
                if (!found || (lvl_i < best_lvl)) begin
                    found = 1'h1;
                    best_lvl = lvl_i;
                    best_idx = VIA_IDX_W'(i);
                end
            end
        end
        if (rst_now) begin
            // [R7] Reset branch.
            nxt_st.rst_br = 1'h1;
            nxt_st.trap = trap_now;
            nxt_st.vec = VIA_VEC_RESET;
        end else if (software_break_instr) begin
            // [R5] Break bypasses enable.
            nxt_st.ack = 1'h1;
            nxt_st.vec = VIA_VEC_BRK;
            nxt_st.lvl = isp;
        end else if (global_irq_enable && accept_window && found) begin
            // [R2] Nesting by level.
            // [R25] Vector and new level.
            nxt_st.ack = 1'h1;
            nxt_st.mask_ack = 1'h1;
            nxt_st.lvl = best_lvl;
            // [R6] Sixteen-bit vector.
            nxt_st.vec = VIA_VEC_BASE + 16'(VIA_VEC_STEP * 16'(best_idx));
            // [R21] Clear on acknowledge.
            ack_clr[best_idx] = 1'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_ff.ack <= 1'h0;
            st_ff.mask_ack <= 1'h0;
            st_ff.vec <= VIA_VEC_RESET;
            st_ff.lvl <= VIA_LVL_LOWEST;
            st_ff.rst_br <= 1'h0;
            st_ff.trap <= 1'h0;
            st_ff.stby <= 1'h0;
            st_ff.mask <= {NUM_SRC{VIA_MASK_RST}};
            st_ff.pr0 <= {NUM_SRC{VIA_PR_RST}};
            st_ff.pr1 <= {NUM_SRC{VIA_PR_RST}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    assign irq_ack_ff = st_ff.ack;
    assign vector_ff = st_ff.vec;
    assign new_level_ff = st_ff.lvl;
    assign reset_branch_ff = st_ff.rst_br;
    assign trap_reset_ff = st_ff.trap;
    assign standby_release_ff = st_ff.stby;
    assign req_flags_ff = flags;
    assign source_mask_flag_ff = st_ff.mask;
    assign priority_select_bit0_ff = st_ff.pr0;
    assign priority_select_bit1_ff = st_ff.pr1;

    // =====================================================================
    // Checks
    // =====================================================================
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    chk_reset_branch: assert property ( // R7
        (ext_reset_pin || watchdog_overflow) |-> ##1 (reset_branch_ff && vector_ff == 16'h0000)
    ) else $error("Reset cause did not branch to vector zero.");

    chk_trap_opcode: assert property ( // R8
        (opcode_exec && opcode_in == 8'hff && !debug_emulation) |-> ##1 trap_reset_ff
    ) else $error("Illegal opcode did not raise trap reset.");

    chk_trap_debug: assert property ( // R9
        trap_reset_ff |-> !$past(debug_emulation)
    ) else $error("Trap reset raised under debug emulation.");

    chk_break_vector: assert property ( // R5
        (software_break_instr && !rst_now) |-> ##1 (irq_ack_ff && vector_ff == 16'h007e)
    ) else $error("Software break not vectored through 007EH.");

    chk_ack_enable: assert property ( // R24
        (irq_ack_ff && vector_ff != 16'h007e) |-> $past(global_irq_enable && accept_window)
    ) else $error("Maskable acknowledge without enable.");

    chk_ack_level: assert property ( // R24
        (irq_ack_ff && vector_ff != 16'h007e) |->
            (new_level_ff <= $past(isp)) && !$past(software_break_instr)
    ) else $error("Acknowledged level below in-service level.");

    chk_mask_reset: assert property ( // R22
        $past(srst) |-> (source_mask_flag_ff == {NUM_SRC{1'b1}})
    ) else $error("Mask bits not set after reset.");

    chk_standby_rel: assert property ( // R4
        (|(flags & ~source_mask_flag_ff)) |-> ##1 standby_release_ff
    ) else $error("Pending unmasked request gave no standby release.");

    chk_vector_range: assert property ( // R6
        irq_ack_ff |-> (vector_ff[0] == 1'b0) && (vector_ff <= 16'h007e)
    ) else $error("Vector outside the table.");

    chk_shared_serial: assert property ( // R23
        (serial_tx_end_req || simple_twowire_end_req) |-> ##1 req_flags_ff[3]
    ) else $error("Shared serial event did not set its flag.");

    chk_wdt_first: assert property ( // R3
        (flags[0] && !source_mask_flag_ff[0] && !st_ff.pr0[0] && !st_ff.pr1[0]
            && global_irq_enable && accept_window && !rst_now && !software_break_instr)
            |-> ##1 (irq_ack_ff && vector_ff == 16'h0004 && new_level_ff == 2'h0)
    ) else $error("Watchdog interval not vectored through 0004H.");

    chk_trap_branch: assert property ( // R7
        trap_reset_ff |-> (reset_branch_ff && vector_ff == 16'h0000)
    ) else $error("Trap reset without branch to vector zero.");

    chk_standby_cause: assert property ( // R4
        standby_release_ff |-> $past(|(flags & ~source_mask_flag_ff))
    ) else $error("Standby release without a pending unmasked request.");

    cov_break: cover property (software_break_instr ##1 irq_ack_ff);
    cov_nested: cover property (irq_ack_ff && new_level_ff < 2'h3 && $past(isp) != 2'h3);
    cov_trap: cover property (trap_reset_ff);
    cov_standby: cover property (standby_release_ff ##1 irq_ack_ff);
endmodule : via_arbiter
`default_nettype wire

// ==== test/via_core_model.sv ====
// Purpose: Core model facing the vectored interrupt arbiter.
// Assumes: A handler return is a one-cycle ret_pulse from the bench.
// Notes: Saves the in-service level on each acknowledge, up to eight deep.
`timescale 1ns/1ns
`default_nettype none
module via_core_model (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic srst,
    // Bench controls.
    input wire logic win_req,
    input wire logic ret_pulse,
    // Arbiter answer.
    input wire logic irq_ack_ff,
    input wire logic [1:0] new_level_ff,
    // Core status.
    output logic accept_window,
    output logic in_service_level_bit0,
    output logic in_service_level_bit1
);
    logic [1:0] lvl_ff;
    logic [1:0] stk_ff [0:7];
    logic [2:0] sp_ff;
    assign accept_window = win_req;
    assign in_service_level_bit0 = lvl_ff[0];
    assign in_service_level_bit1 = lvl_ff[1];
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lvl_ff <= 2'h3;
            sp_ff <= 3'h0;
        end else if (irq_ack_ff) begin
            stk_ff[sp_ff] <= lvl_ff;
            sp_ff <= sp_ff + 3'h1;
            lvl_ff <= new_level_ff;
        end else if (ret_pulse && sp_ff != 3'h0) begin
            lvl_ff <= stk_ff[sp_ff - 3'h1];
            sp_ff <= sp_ff - 3'h1;
        end
    end
endmodule : via_core_model
`default_nettype wire

// ==== test/vectored_interrupt_arbiter_test.sv ====
// Purpose: Self-checking bench for the vectored interrupt arbiter.
// Assumes: Every answer of the arbiter comes one cycle after its request.
// Notes: Events are driven as one vector in port order.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin errors++; \
    $display("unexpected at %0t: got %0h want %0h", $time, got, exp); end end
module vectored_interrupt_arbiter_test
    import via_pkg::*;
;
    logic clk_sys, srst, cfg_wr, win_req, ret_pulse, global_irq_enable;
    logic software_break_instr, opcode_exec, debug_emulation;
    logic ext_reset_pin, selectable_power_on_reset, watchdog_overflow;
    logic accept_window, in_service_level_bit0, in_service_level_bit1;
    logic irq_ack_ff, reset_branch_ff, trap_reset_ff, standby_release_ff;
    logic [21:0] evts;
    logic [7:0] opcode_in;
    logic [15:0] vector_ff;
    logic [1:0] new_level_ff;
    logic [VIA_NUM_SRC-1:0] cfg_mask_in, cfg_pr0_in, cfg_pr1_in, flag_sw_clr;
    logic [VIA_NUM_SRC-1:0] req_flags_ff, source_mask_flag_ff;
    logic [VIA_NUM_SRC-1:0] priority_select_bit0_ff, priority_select_bit1_ff;
    int errors = 0;
    int n_checks = 0;
    int src_of [22] = '{0, 1, 2, 3, 3, 3, 4, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16,
        17, 18};

    via_arbiter #(.NUM_SRC(VIA_NUM_SRC)) via_arbiter_i (.clk_sys, .srst,
        .watchdog_interval_req(evts[0]), .pin_edge_req_0(evts[1]), .pin_edge_req_1(evts[2]),
        .serial_tx_end_req(evts[3]), .clocked_serial0_end_req(evts[4]),
        .simple_twowire_end_req(evts[5]), .serial_rx_end_req(evts[6]),
        .clocked_serial1_end_req(evts[7]), .serial_rx_error_req(evts[8]),
        .timer_ch1_upper_req(evts[9]), .timer_ch0_req(evts[10]), .timer_ch1_req(evts[11]),
        .conversion_done_req(evts[12]), .key_return_req(evts[13]), .pin_edge_req_2(evts[14]),
        .pin_edge_req_3(evts[15]), .timer_ch3_upper_req(evts[16]),
        .twowire_ctrl_end_req(evts[17]), .timer_ch2_req(evts[18]), .timer_ch3_req(evts[19]),
        .interval_timer_req(evts[20]), .comparator_edge_req(evts[21]),
        .cfg_wr, .cfg_mask_in, .cfg_pr0_in, .cfg_pr1_in, .flag_sw_clr, .global_irq_enable,
        .in_service_level_bit0, .in_service_level_bit1, .accept_window, .software_break_instr,
        .opcode_exec, .opcode_in, .debug_emulation, .ext_reset_pin, .selectable_power_on_reset,
        .watchdog_overflow, .irq_ack_ff, .vector_ff, .new_level_ff, .reset_branch_ff,
        .trap_reset_ff, .standby_release_ff, .req_flags_ff, .source_mask_flag_ff,
        .priority_select_bit0_ff, .priority_select_bit1_ff);

    via_core_model via_core_model_i (.clk_sys, .srst, .win_req, .ret_pulse, .irq_ack_ff,
        .new_level_ff, .accept_window, .in_service_level_bit0, .in_service_level_bit1);

    // =====================================================================
    // Access tasks
    // =====================================================================
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    task automatic pulse(input logic [21:0] m);
        @(posedge clk_sys);
        evts <= m;
        @(posedge clk_sys);
        evts <= '0;
        #1;
    endtask : pulse

    task automatic take(input logic want, input logic [15:0] vec, input logic [1:0] lvl);
        @(posedge clk_sys);
        win_req <= 1'b1;
        @(posedge clk_sys);
        win_req <= 1'b0;
        #1;
        `CHK(irq_ack_ff, want)
        if (want) begin
            `CHK(vector_ff, vec)
            `CHK(new_level_ff, lvl)
        end
    endtask : take

    task automatic ret();
        @(posedge clk_sys);
        ret_pulse <= 1'b1;
        @(posedge clk_sys);
        ret_pulse <= 1'b0;
    endtask : ret

    task automatic set_cfg(input logic [18:0] mk, input logic [18:0] p0, input logic [18:0] p1);
        @(posedge clk_sys);
        cfg_wr <= 1'b1;
        cfg_mask_in <= mk;
        cfg_pr0_in <= p0;
        cfg_pr1_in <= p1;
        @(posedge clk_sys);
        cfg_wr <= 1'b0;
    endtask : set_cfg

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #100000;
        errors++;
        $display("unexpected at %0t: run timeout", $time);
        complete_run();
    end

    // =====================================================================
    // Tests
    // =====================================================================
    initial begin
        {srst, global_irq_enable} = 2'h3;
        {cfg_wr, win_req, ret_pulse, software_break_instr, opcode_exec} = 5'h0;
        {debug_emulation, ext_reset_pin, selectable_power_on_reset, watchdog_overflow} = 4'h0;
        evts = '0;
        opcode_in = 8'h00;
        {cfg_mask_in, cfg_pr0_in, cfg_pr1_in, flag_sw_clr} = '0;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        #1;
        `CHK(req_flags_ff, 19'h0)
        `CHK(source_mask_flag_ff, 19'h7ffff)
        `CHK(priority_select_bit0_ff & priority_select_bit1_ff, 19'h7ffff)
        `CHK(vector_ff, 16'h0000)
        pulse(22'h2);
        take(1'b0, 16'h0, 2'h0);
        `CHK({req_flags_ff[1], standby_release_ff}, 2'h2)
        set_cfg(19'h0, 19'h7ffff, 19'h7ffff);
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK(standby_release_ff, 1'b1)
        take(1'b1, 16'h0006, 2'h3);
        ret();
        $display("test reset and mask done");
        for (int i = 0; i < 22; i++) begin
            pulse(22'h1 << i);
            `CHK(req_flags_ff[src_of[i]], 1'b1)
            take(1'b1, 16'h0004 + 16'(2 * src_of[i]), 2'h3);
            `CHK(req_flags_ff[src_of[i]], 1'b0)
            ret();
        end
        $display("test vector table done");
        set_cfg(19'h0, 19'h3ffff, 19'h3ffff);
        pulse(22'h202003);
        take(1'b1, 16'h0028, 2'h0);
        ret();
        take(1'b1, 16'h0004, 2'h3);
        ret();
        take(1'b1, 16'h0006, 2'h3);
        ret();
        take(1'b1, 16'h0018, 2'h3);
        ret();
        $display("test priority order done");
        set_cfg(19'h0, 19'h7fffa, 19'h7fffc);
        pulse(22'h2);
        `CHK({source_mask_flag_ff, priority_select_bit1_ff[2:0], priority_select_bit0_ff[2:0]}, 25'h22)
        take(1'b1, 16'h0006, 2'h1);
        pulse(22'h4);
        take(1'b0, 16'h0, 2'h0);
        pulse(22'h1);
        take(1'b1, 16'h0004, 2'h0);
        ret();
        take(1'b0, 16'h0, 2'h0);
        ret();
        @(posedge clk_sys);
        global_irq_enable <= 1'b0;
        take(1'b0, 16'h0, 2'h0);
        `CHK(req_flags_ff[2], 1'b1)
        @(posedge clk_sys);
        global_irq_enable <= 1'b1;
        take(1'b1, 16'h0008, 2'h2);
        ret();
        $display("test nesting done");
        @(posedge clk_sys);
        global_irq_enable <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            @(posedge clk_sys);
            software_break_instr <= 1'b1;
            @(posedge clk_sys);
            software_break_instr <= 1'b0;
            #1;
            `CHK({irq_ack_ff, vector_ff}, 17'h1007e)
            ret();
            @(posedge clk_sys);
            ext_reset_pin <= (k == 0);
            selectable_power_on_reset <= (k == 1);
            watchdog_overflow <= (k == 2);
            opcode_exec <= (k >= 3);
            opcode_in <= (k == 5) ? 8'hfe : 8'hff;
            debug_emulation <= (k == 4);
            @(posedge clk_sys);
            {ext_reset_pin, selectable_power_on_reset, watchdog_overflow, opcode_exec} <= 4'h0;
            #1;
            `CHK(reset_branch_ff, k < 4)
            `CHK(trap_reset_ff, k == 3)
            `CHK(vector_ff, (k < 4) ? 16'h0000 : 16'h007e)
        end
        pulse(22'h400);
        @(posedge clk_sys);
        flag_sw_clr <= 19'h80;
        #1;
        `CHK({req_flags_ff[7], standby_release_ff}, 2'h3)
        @(posedge clk_sys);
        flag_sw_clr <= 19'h0;
        #1;
        `CHK(req_flags_ff[7], 1'b0)
        $display("test break and reset done");
        complete_run();
    end
endmodule : vectored_interrupt_arbiter_test
`default_nettype wire
